// *** prsi_fault_dec.sv ***
// Decides which fault an x87, media or SIMD instruction raises.
module prsi_fault_dec import prsi_pkg::*; (
  // Core side.
  prsi_fp_if.dec m
);
  logic is_x87;
  logic is_wait;
  logic is_media;
  logic is_simd;
  logic is_save;
  logic nm_hit;
  logic ud_hit;
  logic mf_hit;
  logic xf_hit;

  // Class decode.
  assign is_x87   = m.cls == CLS_X87;
  assign is_wait  = m.cls == CLS_WAIT;
  assign is_media = m.cls == CLS_MEDIA;
  assign is_simd  = m.cls == CLS_SIMD;
  assign is_save  = (m.cls == CLS_SAVE) || (m.cls == CLS_RESTORE);

  // Fault conditions; no-device wins over bad opcode, then pending errors.
  assign nm_hit = m.go && ((is_wait && m.mp && m.ts) || (is_x87 && m.em));
  assign ud_hit = m.go && ((is_media && m.em) || (is_simd && (m.em || !m.sse)));
  assign mf_hit = m.go && (is_x87 || is_wait) && m.x87_exc && m.ne;
  assign xf_hit = m.go && is_simd && m.simd_exc && m.sxe;

  // Save and restore trap to no-device, other SIMD work to bad opcode.
  assign m.fault = (nm_hit || (m.go && is_save && m.em)) ? FLT_NO_DEVICE :
                   (ud_hit || (m.go && is_simd && m.simd_exc && !m.sxe)) ? FLT_BAD_OPCODE :
                   mf_hit ? FLT_FP_PENDING :
                   xf_hit ? FLT_SIMD_FP : FLT_NONE;
  // External error line when native reporting is off.
  assign m.ferr = m.go && !nm_hit && (is_x87 || is_wait) && m.x87_exc && !m.ne;
endmodule

// *** prsi_fp_if.sv ***
// Links the core to the stack memory and to the fault decoder.
interface prsi_fp_if import prsi_pkg::*; #(parameter int W = 80);
  logic           clr;
  logic           wr;
  logic [2:0]     widx;
  logic [W-1:0]   wdata;
  logic [2:0]     ridx;
  logic [W-1:0]   rdata;
  prsi_cls_type   cls;
  logic           go;
  logic           mp;
  logic           em;
  logic           ne;
  logic           ts;
  logic           sse;
  logic           sxe;
  logic           x87_exc;
  logic           simd_exc;
  prsi_fault_type fault;
  logic           ferr;
  modport core (output clr, wr, widx, wdata, ridx, cls, go, mp, em, ne, ts, sse, sxe,
                x87_exc, simd_exc, input rdata, fault, ferr);
  modport mem (input clr, wr, widx, wdata, ridx, output rdata);
  modport dec (input cls, go, mp, em, ne, ts, sse, sxe, x87_exc, simd_exc,
               output fault, ferr);
endinterface

// *** prsi_fpr_mem.sv ***
// Stack register file; the low 64 bits of each entry hold the media state.
module prsi_fpr_mem #(
  parameter int DEPTH = 8
) (
  // Clock.
  input wire logic clk_i,
  // Core side.
  prsi_fp_if.mem   m
);
  logic [$bits(m.wdata)-1:0] mem_r [DEPTH];

  // Clear on hard reset only, else write; read data is registered.
  always_ff @(posedge clk_i)
  begin
    if (m.clr)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem_r[i] <= '0;
    end
    else if (m.wr)
      mem_r[m.widx] <= m.wdata;
    m.rdata <= mem_r[m.ridx];
  end
endmodule

// *** prsi_map.svh ***
// Fixed reset values, codes and selectors of the reset-state block.
`ifndef PRSI_MAP_SVH
`define PRSI_MAP_SVH
// Code segment and first fetch.
`define PRSI_CS_SEL_RST   16'hF000
`define PRSI_CS_BASE_RST  32'hFFFF_0000
`define PRSI_IP_RST       32'h0000_FFF0
`define PRSI_REAL_MASK    32'h000F_FFFF
// Attribute word is G, D/B, L, P, level[1:0], S, type[3:0].
`define PRSI_ATTR_CODE    11'h09A
`define PRSI_ATTR_DATA    11'h092
`define PRSI_ATTR_LDT     11'h082
`define PRSI_ATTR_TASK    11'h083
// Cache and x87 values.
`define PRSI_CD_RST       1'h1
`define PRSI_FP_CW_RST    16'h0040
`define PRSI_FP_SW_RST    16'h0000
`define PRSI_FP_TW_RST    16'h5555
`define PRSI_FP_CW_INIT   16'h037F
`define PRSI_FP_TW_INIT   16'hFFFF
`define PRSI_SIMD_CSR_RST 32'h0000_1F80
// Identify functions.
`define PRSI_IDFN_STD     32'h0000_0001
`define PRSI_IDFN_EXT     32'h8000_0001
// Selectors of the x87 access port.
`define PRSI_FPSEL_CW     3'h0
`define PRSI_FPSEL_SW     3'h1
`define PRSI_FPSEL_TW     3'h2
`define PRSI_FPSEL_ICS    3'h3
`define PRSI_FPSEL_IOFF   3'h4
`define PRSI_FPSEL_OPC    3'h5
`define PRSI_FPSEL_DDS    3'h6
`define PRSI_FPSEL_DOFF   3'h7
`endif

// *** prsi_pkg.sv ***
// Types shared by the reset-state block.
package prsi_pkg;
  typedef enum logic [1:0] {SEQ_HARD, SEQ_WARM, SEQ_FETCH, SEQ_RUN} prsi_seq_type;
  typedef enum logic [2:0] {CLS_OTHER, CLS_X87, CLS_WAIT, CLS_MEDIA, CLS_SIMD,
                            CLS_SAVE, CLS_RESTORE} prsi_cls_type;
  typedef enum logic [2:0] {FLT_NONE, FLT_NO_DEVICE, FLT_FP_PENDING, FLT_BAD_OPCODE,
                            FLT_SIMD_FP} prsi_fault_type;
endpackage

// *** prsi_reset_init.sv ***
// Reset and warm-restart state of the core.
// Contract
// - Segment attributes reset to byte granular, 16-bit, legacy, present, level zero.
// - Type codes: code 1/1010, data 1/0010, local table 0/0010, task 0/0011.
// - Both restarts leave the core in 16-bit real mode.
// - Real mode base is selector shifted by four plus pointer, first megabyte.
// - Restart loads selector F000h, base FFFF0000h, pointer FFF0h.
// - Special base holds until software loads the code selector.
// - Id word holds revision 3:0, model 7:4 and extended model 19:16.
// - Id word holds family 11:8 and extended family 27:20.
// - Identify with function 1 or 8000_0001h returns the id word.
// - Hard reset only sets cache disable and invalidates caches.
// - Hard reset only clears the memory-type default register.
// - Warm restart leaves x87 state unchanged.
// - Hard reset sets x87 words 0040h, 0000h, 5555h, stack and pointers zero.
// - Reinit sets control 037Fh and tag FFFFh, keeps stack and media.
// - Wait with monitor and task switched bits raises no-device.
// - Soft trap bit makes x87 instructions raise no-device.
// - Native bit routes x87 errors to pending fault, else external line.
// - Hard reset clears media state, warm keeps it; trap bit gives bad opcode.
// - Trap bit: SIMD gives bad opcode, save and restore give no-device.
// - SIMD runs only with the sse enable bit set.
// - Simd exception enable routes SIMD errors to the simd fault.
`include "prsi_map.svh"
module prsi_reset_init import prsi_pkg::*; #(
  parameter logic [3:0] STEPPING    = 4'h0, // Arbitrary identity value.
  parameter logic [3:0] BASE_MODEL  = 4'h1, // Arbitrary identity value.
  parameter logic [3:0] EXT_MODEL   = 4'h0, // Arbitrary identity value.
  parameter logic [3:0] BASE_FAMILY = 4'h2, // Arbitrary identity value.
  parameter logic [7:0] EXT_FAMILY  = 8'h00, // Arbitrary identity value.
  parameter int         MT_W        = 12
) (
  // Clock and reset.
  input  wire logic             CLOCK_I,
  input  wire logic             RESET_I,
  // Warm restart pin.
  input  wire logic             INIT_I,
  // Sequencing.
  output logic                  CORE_READY_O,
  output logic                  FIRST_FETCH_O,
  output logic [31:0]           FETCH_ADDR_O,
  output logic                  REAL16_O,
  input  wire logic             PROT_EN_I,
  // Code segment and instruction pointer.
  input  wire logic             CS_LOAD_I,
  input  wire logic [15:0]      CS_SEL_I,
  input  wire logic             IP_LOAD_I,
  input  wire logic [31:0]      IP_I,
  output logic [15:0]           CS_SEL_O,
  output logic [31:0]           CS_BASE_O,
  output logic [31:0]           IP_O,
  // Hidden attributes.
  output logic [10:0]           CS_ATTR_O,
  output logic [10:0]           DATA_ATTR_O,
  output logic [10:0]           LDT_ATTR_O,
  output logic [10:0]           TASK_ATTR_O,
  // Identification.
  input  wire logic             ID_WR_I,
  input  wire logic [31:0]      ID_WDATA_I,
  output logic [31:0]           ID_RESULT_O,
  input  wire logic             IDENT_REQ_I,
  input  wire logic [31:0]      IDENT_FN_I,
  output logic                  IDENT_VALID_O,
  output logic [31:0]           IDENT_DATA_O,
  // Cache and memory type.
  input  wire logic             CD_WR_I,
  input  wire logic             CD_I,
  output logic                  CACHE_DIS_O,
  output logic                  CACHE_INVAL_O,
  input  wire logic             MT_WR_I,
  input  wire logic [MT_W-1:0]  MT_I,
  output logic [MT_W-1:0]       MT_DEF_O,
  // x87 words and pointers.
  input  wire logic             FP_REINIT_I,
  input  wire logic             FPU_WR_I,
  input  wire logic [2:0]       FPU_SEL_I,
  input  wire logic [31:0]      FPU_WDATA_I,
  output logic [31:0]           FPU_RDATA_O,
  // Stack and media registers.
  input  wire logic             FPR_WR_I,
  input  wire logic [2:0]       FPR_WIDX_I,
  input  wire logic [79:0]      FPR_WDATA_I,
  input  wire logic [2:0]       FPR_RIDX_I,
  output logic [79:0]           FPR_RDATA_O,
  // SIMD control and status.
  input  wire logic             SIMD_CSR_WR_I,
  input  wire logic [31:0]      SIMD_CSR_I,
  output logic [31:0]           SIMD_CSR_O,
  // Control bits.
  input  wire logic             MONITOR_COPROC_BIT_I,
  input  wire logic             SOFT_FP_TRAP_BIT_I,
  input  wire logic             FP_ERR_NATIVE_BIT_I,
  input  wire logic             TASK_SWITCHED_BIT_I,
  input  wire logic             SSE_ENABLE_BIT_I,
  input  wire logic             SIMD_EXC_ENABLE_BIT_I,
  // Instruction checks and faults.
  input  wire logic             INSN_VALID_I,
  input  wire logic [2:0]       INSN_CLASS_I,
  input  wire logic             X87_EXC_I,
  input  wire logic             SIMD_EXC_I,
  output logic                  FAULT_VALID_O,
  output logic [2:0]            FAULT_CODE_O,
  output logic                  FP_ERR_EXT_O
);
  // ----------------------------------------------------------------
  // Restart sampling and sequence
  // ----------------------------------------------------------------
  prsi_seq_type   seq_r;
  prsi_seq_type   seq_nxt;
  logic           init_s1_r;
  logic           init_s2_r;
  logic           init_s3_r;
  logic           warm_go;
  logic           run;
  logic           sw_ok;

  // Restart pin passes two flops, a third marks its rising edge.
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      init_s1_r <= 1'b0;
      init_s2_r <= 1'b0;
      init_s3_r <= 1'b0;
    end
    else
    begin
      init_s1_r <= INIT_I;
      init_s2_r <= init_s1_r;
      init_s3_r <= init_s2_r;
    end
  end

  // Warm restart request and software access window.
  assign warm_go = init_s2_r && !init_s3_r;
  assign run     = seq_r == SEQ_RUN;
  assign sw_ok   = run && !warm_go;

  // Next sequence state: restart values first, then one fetch cycle.
  always_comb
  begin
    case (seq_r)
      SEQ_HARD:  seq_nxt = SEQ_FETCH;
      SEQ_WARM:  seq_nxt = SEQ_FETCH;
      SEQ_FETCH: seq_nxt = SEQ_RUN;
      SEQ_RUN:   seq_nxt = SEQ_RUN;
      default:   seq_nxt = SEQ_HARD;
    endcase
    if (warm_go)
      seq_nxt = SEQ_WARM;
  end

  // Sequence register.
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
      seq_r <= SEQ_HARD;
    else
      seq_r <= seq_nxt;
  end

  assign CORE_READY_O  = run;
  assign FIRST_FETCH_O = seq_r == SEQ_FETCH;

  // ----------------------------------------------------------------
  // Code segment, attributes and fetch address
  // ----------------------------------------------------------------
  logic [15:0] cs_sel_r;
  logic [31:0] cs_base_r;
  logic [31:0] ip_r;
  logic        special_r;
  logic        real16_r;
  logic [10:0] cs_attr_r;
  logic [10:0] data_attr_r;
  logic [10:0] ldt_attr_r;
  logic [10:0] task_attr_r;
  logic [31:0] fetch_sum;
  logic [31:0] fetch_addr_nxt;
  logic [31:0] fetch_addr_r;

  // Real mode base of a selector.
  function automatic logic [31:0] real_base(input logic [15:0] sel);
    real_base = {12'h000, sel, 4'h0};
  endfunction

  // Restart loads the special base; a software load returns to the shift rule.
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I || warm_go)
    begin
      cs_sel_r    <= `PRSI_CS_SEL_RST;
      cs_base_r   <= `PRSI_CS_BASE_RST;
      ip_r        <= `PRSI_IP_RST;
      special_r   <= 1'b1;
      real16_r    <= 1'b1;
      cs_attr_r   <= `PRSI_ATTR_CODE;
      data_attr_r <= `PRSI_ATTR_DATA;
      ldt_attr_r  <= `PRSI_ATTR_LDT;
      task_attr_r <= `PRSI_ATTR_TASK;
    end
    else if (sw_ok)
    begin
      if (CS_LOAD_I)
      begin
        cs_sel_r  <= CS_SEL_I;
        cs_base_r <= real_base(CS_SEL_I);
        special_r <= 1'b0;
      end
      if (IP_LOAD_I)
        ip_r <= IP_I;
      if (PROT_EN_I)
        real16_r <= 1'b0;
    end
  end

  // Real mode wraps at one megabyte except under the special base.
  assign fetch_sum      = cs_base_r + ip_r;
  assign fetch_addr_nxt = (special_r || !real16_r) ? fetch_sum
                                                   : (fetch_sum & `PRSI_REAL_MASK);

  // Fetch address register.
  always_ff @(posedge CLOCK_I)
  begin
    fetch_addr_r <= fetch_addr_nxt;
  end

  assign FETCH_ADDR_O = fetch_addr_r;
  assign REAL16_O     = real16_r;
  assign CS_SEL_O     = cs_sel_r;
  assign CS_BASE_O    = cs_base_r;
  assign IP_O         = ip_r;
  assign CS_ATTR_O    = cs_attr_r;
  assign DATA_ATTR_O  = data_attr_r;
  assign LDT_ATTR_O   = ldt_attr_r;
  assign TASK_ATTR_O  = task_attr_r;

  // ----------------------------------------------------------------
  // Identification, cache and memory type
  // ----------------------------------------------------------------
  logic [31:0]     id_word;
  logic [31:0]     id_r;
  logic            ident_hit;
  logic            ident_valid_r;
  logic [31:0]     ident_data_r;
  logic            cd_r;
  logic            inval_r;
  logic [MT_W-1:0] mt_r;

  // Id word: ext family 27:20, ext model 19:16, family 11:8, model 7:4, revision 3:0.
  assign id_word   = {4'h0, EXT_FAMILY, EXT_MODEL, 4'h0, BASE_FAMILY, BASE_MODEL, STEPPING};
  assign ident_hit = (IDENT_FN_I == `PRSI_IDFN_STD) || (IDENT_FN_I == `PRSI_IDFN_EXT);

  // Id result register and identify answer.
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I || warm_go)
      id_r <= id_word;
    else if (sw_ok && ID_WR_I)
      id_r <= ID_WDATA_I;
    ident_valid_r <= !RESET_I && sw_ok && IDENT_REQ_I;
    ident_data_r  <= ident_hit ? id_word : 32'h0000_0000;
  end

  // Cache disable, invalidate pulse and memory-type default; warm restart keeps them.
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      cd_r    <= `PRSI_CD_RST;
      inval_r <= 1'b1;
      mt_r    <= '0;
    end
    else
    begin
      inval_r <= 1'b0;
      if (sw_ok && CD_WR_I)
        cd_r <= CD_I;
      if (sw_ok && MT_WR_I)
        mt_r <= MT_I;
    end
  end

  assign ID_RESULT_O   = id_r;
  assign IDENT_VALID_O = ident_valid_r;
  assign IDENT_DATA_O  = ident_data_r;
  assign CACHE_DIS_O   = cd_r;
  assign CACHE_INVAL_O = inval_r;
  assign MT_DEF_O      = mt_r;

  // ----------------------------------------------------------------
  // x87, media and SIMD state
  // ----------------------------------------------------------------
  logic [15:0]    fp_cw_r;
  logic [15:0]    fp_sw_r;
  logic [15:0]    fp_tw_r;
  logic [15:0]    fp_ics_r;
  logic [31:0]    fp_ioff_r;
  logic [10:0]    fp_opc_r;
  logic [15:0]    fp_dds_r;
  logic [31:0]    fp_doff_r;
  logic [31:0]    fpu_rd_nxt;
  logic [31:0]    fpu_rd_r;
  logic [31:0]    simd_csr_r;
  prsi_fault_type fault_r;
  logic           ferr_r;

  // Hard reset sets the x87 words; warm restart leaves them; reinit resets two.
  always_ff @(posedge CLOCK_I)
  begin
    if (RESET_I)
    begin
      fp_cw_r    <= `PRSI_FP_CW_RST;
      fp_sw_r    <= `PRSI_FP_SW_RST;
      fp_tw_r    <= `PRSI_FP_TW_RST;
      fp_ics_r   <= '0;
      fp_ioff_r  <= '0;
      fp_opc_r   <= '0;
      fp_dds_r   <= '0;
      fp_doff_r  <= '0;
      simd_csr_r <= `PRSI_SIMD_CSR_RST;
    end
    else if (sw_ok)
    begin
      if (SIMD_CSR_WR_I)
        simd_csr_r <= SIMD_CSR_I;
      if (FP_REINIT_I)
      begin
        fp_cw_r <= `PRSI_FP_CW_INIT;
        fp_tw_r <= `PRSI_FP_TW_INIT;
      end
      else if (FPU_WR_I)
      begin
        case (FPU_SEL_I)
          `PRSI_FPSEL_CW:   fp_cw_r   <= FPU_WDATA_I[15:0];
          `PRSI_FPSEL_SW:   fp_sw_r   <= FPU_WDATA_I[15:0];
          `PRSI_FPSEL_TW:   fp_tw_r   <= FPU_WDATA_I[15:0];
          `PRSI_FPSEL_ICS:  fp_ics_r  <= FPU_WDATA_I[15:0];
          `PRSI_FPSEL_IOFF: fp_ioff_r <= FPU_WDATA_I;
          `PRSI_FPSEL_OPC:  fp_opc_r  <= FPU_WDATA_I[10:0];
          `PRSI_FPSEL_DDS:  fp_dds_r  <= FPU_WDATA_I[15:0];
          default:          fp_doff_r <= FPU_WDATA_I;
        endcase
      end
    end
  end

  // Read selection of the x87 words.
  always_comb
  begin
    case (FPU_SEL_I)
      `PRSI_FPSEL_CW:   fpu_rd_nxt = {16'h0000, fp_cw_r};
      `PRSI_FPSEL_SW:   fpu_rd_nxt = {16'h0000, fp_sw_r};
      `PRSI_FPSEL_TW:   fpu_rd_nxt = {16'h0000, fp_tw_r};
      `PRSI_FPSEL_ICS:  fpu_rd_nxt = {16'h0000, fp_ics_r};
      `PRSI_FPSEL_IOFF: fpu_rd_nxt = fp_ioff_r;
      `PRSI_FPSEL_OPC:  fpu_rd_nxt = {21'h000000, fp_opc_r};
      `PRSI_FPSEL_DDS:  fpu_rd_nxt = {16'h0000, fp_dds_r};
      default:          fpu_rd_nxt = fp_doff_r;
    endcase
  end

  prsi_fp_if #(.W(80)) fpi ();

  // Stack memory is cleared by hard reset only; reinit does not touch it.
  assign fpi.clr      = RESET_I;
  assign fpi.wr       = sw_ok && FPR_WR_I;
  assign fpi.widx     = FPR_WIDX_I;
  assign fpi.wdata    = FPR_WDATA_I;
  assign fpi.ridx     = FPR_RIDX_I;
  // Fault decoder inputs; checks apply only once the core runs.
  assign fpi.go       = run && INSN_VALID_I;
  assign fpi.cls      = prsi_cls_type'(INSN_CLASS_I);
  assign fpi.mp       = MONITOR_COPROC_BIT_I;
  assign fpi.em       = SOFT_FP_TRAP_BIT_I;
  assign fpi.ne       = FP_ERR_NATIVE_BIT_I;
  assign fpi.ts       = TASK_SWITCHED_BIT_I;
  assign fpi.sse      = SSE_ENABLE_BIT_I;
  assign fpi.sxe      = SIMD_EXC_ENABLE_BIT_I;
  assign fpi.x87_exc  = X87_EXC_I;
  assign fpi.simd_exc = SIMD_EXC_I;

  prsi_fpr_mem #(.DEPTH(8)) u_mem (
    .clk_i (CLOCK_I),
    .m     (fpi.mem)
  );

  prsi_fault_dec u_dec (
    .m (fpi.dec)
  );

  // Registered read data and fault report.
  always_ff @(posedge CLOCK_I)
  begin
    fpu_rd_r <= fpu_rd_nxt;
    fault_r  <= RESET_I ? FLT_NONE : fpi.fault;
    ferr_r   <= !RESET_I && fpi.ferr;
  end

  assign FPU_RDATA_O   = fpu_rd_r;
  assign FPR_RDATA_O   = fpi.rdata;
  assign SIMD_CSR_O    = simd_csr_r;
  assign FAULT_VALID_O = fault_r != FLT_NONE;
  assign FAULT_CODE_O  = fault_r;
  assign FP_ERR_EXT_O  = ferr_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RESET_I);

  AST_FIRST_FETCH: assert property (FIRST_FETCH_O |-> FETCH_ADDR_O == 32'hFFFF_FFF0 && REAL16_O)
    else $error("First fetch not at the restart address.");
  AST_BASE_HOLD: assert property (special_r && !(sw_ok && CS_LOAD_I) |=> cs_base_r == `PRSI_CS_BASE_RST)
    else $error("Special code base changed without a selector load.");
  AST_REAL_SHIFT: assert property (sw_ok && CS_LOAD_I |=> !special_r && cs_base_r == {12'h000, $past(CS_SEL_I), 4'h0})
    else $error("Selector load did not shift into the base.");
  AST_ATTR: assert property (FIRST_FETCH_O |-> cs_attr_r == 11'h09A && data_attr_r == 11'h092 && ldt_attr_r == 11'h082 && task_attr_r == 11'h083)
    else $error("Segment attributes wrong at first fetch.");
  AST_ID: assert property (FIRST_FETCH_O |-> id_r == id_word)
    else $error("Id result register wrong at first fetch.");
  AST_IDENT: assert property (sw_ok && IDENT_REQ_I && IDENT_FN_I == 32'h8000_0001 |=> IDENT_VALID_O && IDENT_DATA_O == id_word)
    else $error("Extended identify did not return the id word.");
  AST_HARD_CACHE: assert property ($fell(RESET_I) |-> cd_r && inval_r && mt_r == '0 ##1 !inval_r)
    else $error("Hard reset cache state wrong.");
  AST_HARD_FP: assert property ($fell(RESET_I) |-> fp_cw_r == 16'h0040 && fp_tw_r == 16'h5555 && fp_sw_r == 16'h0000)
    else $error("Hard reset x87 state wrong.");
  AST_WARM_KEEP: assert property (warm_go |=> $stable(cd_r) && $stable(mt_r) && $stable(fp_cw_r) && $stable(fp_tw_r) && $stable(simd_csr_r))
    else $error("Warm restart changed kept state.");
  AST_REINIT: assert property (sw_ok && FP_REINIT_I |=> fp_cw_r == 16'h037F && fp_tw_r == 16'hFFFF && $stable(fp_sw_r))
    else $error("Reinit values wrong.");
  AST_NM_WAIT: assert property (fpi.go && fpi.cls == CLS_WAIT && fpi.mp && fpi.ts |=> FAULT_CODE_O == FLT_NO_DEVICE)
    else $error("Wait did not raise no-device.");
  AST_SIMD_OFF: assert property (fpi.go && fpi.cls == CLS_SIMD && !fpi.sse |=> FAULT_CODE_O == FLT_BAD_OPCODE)
    else $error("SIMD ran with the enable bit clear.");
  AST_FP_EXT: assert property (fpi.go && fpi.cls == CLS_X87 && !fpi.em && fpi.x87_exc && !fpi.ne |=> FP_ERR_EXT_O && !FAULT_VALID_O)
    else $error("x87 error not signalled externally.");
  AST_SEQ: assert property ($fell(RESET_I) && !warm_go |=> FIRST_FETCH_O ##1 CORE_READY_O)
    else $error("Restart sequence out of order.");

  COV_WARM: cover property (warm_go ##2 FIRST_FETCH_O);
  COV_FAR_JUMP: cover property (sw_ok && CS_LOAD_I && special_r);
  COV_REINIT: cover property (sw_ok && FP_REINIT_I);
  COV_SIMD_FAULT: cover property (FAULT_CODE_O == FLT_SIMD_FP);
endmodule

// *** tb_top.sv ***
// Self-checking bench for the reset and warm-restart state block.
module tb_top;
  import prsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // -----------------------------------------------------------------
  // Stimulus and observed signals
  // -----------------------------------------------------------------
  logic CLOCK_I = 0, RESET_I = 1, INIT_I = 0, PROT_EN_I = 0, CS_LOAD_I = 0, IP_LOAD_I = 0;
  logic ID_WR_I = 0, IDENT_REQ_I = 0, CD_WR_I = 0, CD_I = 0, MT_WR_I = 0, FP_REINIT_I = 0;
  logic FPU_WR_I = 0, FPR_WR_I = 0, SIMD_CSR_WR_I = 0, INSN_VALID_I = 0;
  logic X87_EXC_I = 0, SIMD_EXC_I = 0, MONITOR_COPROC_BIT_I = 0, SOFT_FP_TRAP_BIT_I = 0;
  logic FP_ERR_NATIVE_BIT_I = 0, TASK_SWITCHED_BIT_I = 0, SSE_ENABLE_BIT_I = 0;
  logic SIMD_EXC_ENABLE_BIT_I = 0;
  logic [2:0]  FPU_SEL_I = 0, FPR_WIDX_I = 0, FPR_RIDX_I = 0, INSN_CLASS_I = 0;
  logic [15:0] CS_SEL_I = 0;
  logic [31:0] IP_I = 0, ID_WDATA_I = 0, IDENT_FN_I = 0, FPU_WDATA_I = 0, SIMD_CSR_I = 0;
  logic [11:0] MT_I = 0, MT_DEF_O;
  logic [79:0] FPR_WDATA_I = 0, FPR_RDATA_O;
  logic CORE_READY_O, FIRST_FETCH_O, REAL16_O, IDENT_VALID_O, CACHE_DIS_O, CACHE_INVAL_O;
  logic FAULT_VALID_O, FP_ERR_EXT_O;
  logic [31:0] FETCH_ADDR_O, CS_BASE_O, IP_O, ID_RESULT_O, IDENT_DATA_O, FPU_RDATA_O, SIMD_CSR_O;
  logic [15:0] CS_SEL_O;
  logic [10:0] CS_ATTR_O, DATA_ATTR_O, LDT_ATTR_O, TASK_ATTR_O;
  logic [2:0]  FAULT_CODE_O;
  int          err_count = 0;
  int          check_count = 0;
  // Identity values are arbitrary, chosen so every field differs.
  prsi_reset_init #(.STEPPING(4'h3), .BASE_MODEL(4'h5), .EXT_MODEL(4'h6),
    .BASE_FAMILY(4'hF), .EXT_FAMILY(8'hA1)) dut (.*);
  // Free-running core clock.
  always #5 CLOCK_I = ~CLOCK_I;
  // -----------------------------------------------------------------
  // Shared tasks
  // -----------------------------------------------------------------
  task automatic cyc(input int n = 1);
    repeat (n) @(negedge CLOCK_I);
  endtask
  task automatic chk(input logic [79:0] g, input logic [79:0] e);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Waits a bounded time for the first fetch pulse, then checks run one cycle later.
  task automatic wait_fetch();
    int i;
    for (i = 0; i < 12 && FIRST_FETCH_O !== 1'b1; i++) cyc();
    if (FIRST_FETCH_O !== 1'b1)
    begin
      err_count++;
      $display("[ERR] %0t no first fetch", $time);
      summarize();
    end
    chk(FETCH_ADDR_O, 32'hFFFF_FFF0);
    cyc();
    chk(CORE_READY_O, 1'h1);
  endtask
  // Reads one x87 word through the access port.
  task automatic rd_fpu(input logic [2:0] s, input logic [31:0] e);
    FPU_SEL_I = s;
    cyc();
    chk(FPU_RDATA_O, e);
  endtask
  // Issues one instruction check under the given control bits.
  task automatic flt(input logic [5:0] b, input logic [1:0] x, input logic [2:0] c,
                     input logic [2:0] e);
    {MONITOR_COPROC_BIT_I, SOFT_FP_TRAP_BIT_I, FP_ERR_NATIVE_BIT_I, TASK_SWITCHED_BIT_I,
     SSE_ENABLE_BIT_I, SIMD_EXC_ENABLE_BIT_I} = b;
    {X87_EXC_I, SIMD_EXC_I} = x;
    INSN_CLASS_I = c;
    INSN_VALID_I = 1;
    cyc();
    INSN_VALID_I = 0;
    chk({FAULT_VALID_O, FAULT_CODE_O}, {|e, e});
    chk(FP_ERR_EXT_O, x[1] & ~b[3] & ~b[4] & (c == 3'h1));
    // Let one edge pass so the next call does not re-raise valid in this step.
    cyc();
  endtask
  // -----------------------------------------------------------------
  // Scenarios
  // -----------------------------------------------------------------
  task automatic t_hard();
    cyc(4);
    RESET_I = 0;
    chk(CACHE_INVAL_O, 1'b1);
    wait_fetch();
    chk({CS_SEL_O, CS_BASE_O, IP_O}, {16'hF000, 32'hFFFF_0000, 32'h0000_FFF0});
    chk({CS_ATTR_O, DATA_ATTR_O}, {11'h09A, 11'h092});
    chk({LDT_ATTR_O, TASK_ATTR_O}, {11'h082, 11'h083});
    chk({REAL16_O, CACHE_DIS_O, CACHE_INVAL_O, MT_DEF_O}, {3'h6, 12'h000});
    chk(ID_RESULT_O, 32'h0A16_0F53);
    chk(SIMD_CSR_O, 32'h0000_1F80);
    rd_fpu(3'h0, 32'h0000_0040);
    rd_fpu(3'h1, 32'h0000_0000);
    rd_fpu(3'h2, 32'h0000_5555);
    rd_fpu(3'h7, 32'h0000_0000);
    chk(FPR_RDATA_O, 80'h0);
    $display("test hard reset done");
  endtask
  task automatic t_ident();
    IDENT_FN_I = 32'h0000_0001;
    IDENT_REQ_I = 1;
    cyc();
    chk({IDENT_VALID_O, IDENT_DATA_O}, {1'b1, 32'h0A16_0F53});
    IDENT_FN_I = 32'h8000_0001;
    cyc();
    IDENT_REQ_I = 0;
    chk({IDENT_VALID_O, IDENT_DATA_O}, {1'b1, 32'h0A16_0F53});
    $display("test identify done");
  endtask
  task automatic t_faults();
    flt(6'b100100, 2'b00, 3'h2, 3'h1);
    flt(6'b010000, 2'b00, 3'h1, 3'h1);
    flt(6'b001000, 2'b10, 3'h1, 3'h2);
    flt(6'b000000, 2'b10, 3'h1, 3'h0);
    flt(6'b010000, 2'b00, 3'h3, 3'h3);
    flt(6'b010010, 2'b00, 3'h4, 3'h3);
    flt(6'b010010, 2'b00, 3'h5, 3'h1);
    flt(6'b010010, 2'b00, 3'h6, 3'h1);
    flt(6'b000001, 2'b00, 3'h4, 3'h3);
    flt(6'b000011, 2'b01, 3'h4, 3'h4);
    $display("test faults done");
  endtask
  task automatic t_warm();
    // Software loads selector, pointer, cache, range typing and kept state.
    {CS_LOAD_I, CS_SEL_I, IP_LOAD_I, IP_I, CD_WR_I, MT_WR_I, MT_I} =
      {17'h11234, 33'h1_000F_FFFF, 2'b11, 12'h805};
    {FPR_WR_I, FPR_WIDX_I, FPR_WDATA_I} = {4'hA, 80'h5A};
    {ID_WR_I, SIMD_CSR_WR_I, SIMD_CSR_I, FPU_WR_I, FPU_SEL_I, FPU_WDATA_I} =
      {2'b11, 32'h1F00, 4'h9, 32'h00AB};
    cyc();
    {CS_LOAD_I, IP_LOAD_I, CD_WR_I, MT_WR_I, FPR_WR_I, ID_WR_I, SIMD_CSR_WR_I, FPU_WR_I} = 8'h00;
    {PROT_EN_I, FP_REINIT_I} = 2'b11;
    FPR_RIDX_I = 3'h2;
    chk({CS_SEL_O, CS_BASE_O}, {16'h1234, 32'h0001_2340});
    chk({ID_RESULT_O, SIMD_CSR_O}, 64'h0000_1F00);
    cyc();
    {PROT_EN_I, FP_REINIT_I} = 2'b00;
    chk({REAL16_O, FETCH_ADDR_O}, {1'b0, 32'h0001_233F});
    chk(FPR_RDATA_O, 80'h5A);
    rd_fpu(3'h2, 32'h0000_FFFF);
    INIT_I = 1;
    cyc(3);
    wait_fetch();
    INIT_I = 0;
    chk({CS_SEL_O, CS_BASE_O, REAL16_O}, {16'hF000, 32'hFFFF_0000, 1'b1});
    chk({CACHE_DIS_O, MT_DEF_O}, 13'h0805);
    chk({ID_RESULT_O, SIMD_CSR_O}, {32'h0A16_0F53, 32'h1F00});
    rd_fpu(3'h0, 32'h0000_037F);
    rd_fpu(3'h1, 32'h0000_00AB);
    chk(FPR_RDATA_O, 80'h5A);
    $display("test warm restart done");
  endtask
  // Main sequence.
  initial
  begin
    t_hard();
    t_ident();
    t_faults();
    t_warm();
    summarize();
  end
endmodule
